// [design/tacf_pkg.sv]
// shared constants and carrier types for the thermal alarm coil flag bank
package tacf_pkg;
    // coil addresses
    localparam logic [15:0] TACF_ADDR_DIR = 16'h0004;
    localparam logic [15:0] TACF_ADDR_EN1 = 16'h0005;
    localparam logic [15:0] TACF_ADDR_EN2 = 16'h0006;
    localparam logic [15:0] TACF_ADDR_EN3 = 16'h0007;
    localparam logic [15:0] TACF_ADDR_FRZ = 16'h0008;
    localparam logic [15:0] TACF_ADDR_LIM = 16'h0009;
    localparam logic [15:0] TACF_ADDR_AVG = 16'h000A;
    localparam logic [15:0] TACF_ADDR_CLR = 16'h000B;
    localparam logic [15:0] TACF_ADDR_CRS = 16'h000C;

    typedef struct packed {
        logic cnt_reset;
        logic out_clear;
        logic smooth;
        logic lim_view;
        logic freeze;
        logic [2:0] alarm_en;
        logic uni_dir;
    } tacf_coils_t;

    // all coils read 0 after reset
    localparam logic [8:0] TACF_COILS_RST = 9'h000;
    // coils kept across power cycles: smooth, lim_view, alarm_en, uni_dir
    localparam logic [8:0] TACF_RETAIN_MASK = 9'h06F;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic wdata;
    } tacf_coil_req_t;

    typedef struct packed {
        logic valid;
        logic [9:0] addr;
        logic [15:0] data;
    } tacf_pix_wr_t;

    // pixel frame and read limits
    localparam int TACF_PIX_COUNT = 1024;
    localparam logic [10:0] TACF_MAX_READ = 11'h07D;
    localparam logic [11:0] TACF_PIX_END = 12'h400;
    localparam int TACF_ROI_BITS = 256;
    localparam logic [15:0] TACF_CNT_MAX = 16'hFFFF;
    localparam logic [7:0] TACF_SCAN_LAST = 8'hFF;

    // on-timer time base
    localparam int TACF_CLK_NS = 8;
    localparam int TACF_MS_NS = 1000000;
    localparam int TACF_MS_CYCLES = TACF_MS_NS / TACF_CLK_NS;
endpackage : tacf_pkg

// [design/tacf_pixel_mem.sv]
// pixel temperature store with registered read port
module tacf_pixel_mem (
    // clock
    input wire logic ref_clk,
    // write side
    input wire logic we,
    input wire logic [9:0] waddr,
    input wire logic [15:0] wdata,
    // read side
    input wire logic re,
    input wire logic [9:0] raddr,
    output logic [15:0] rdata_r
);
    import tacf_pkg::*;

    logic [15:0] mem [TACF_PIX_COUNT];

    always_ff @(posedge ref_clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // no reset on the read data: contents are only meaningful once valid
    always_ff @(posedge ref_clk) begin
        if (re) begin
            rdata_r <= mem[raddr];
        end
    end
endmodule : tacf_pixel_mem

// [design/tacf_hotspot_counter.sv]
// region hotspot counter, scans the hotspot array one bit per cycle
module tacf_hotspot_counter (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // frame input
    input wire logic frame_pulse,
    input wire logic [255:0] hot_bits,
    // control
    input wire logic uni_dir,
    input wire logic clear,
    // result
    output logic [15:0] count_r,
    output logic busy_r
);
    import tacf_pkg::*;

    typedef enum logic [0:0] {
        TACF_SCAN_IDLE = 1'b0,
        TACF_SCAN_RUN = 1'b1
    } tacf_scan_t;

    tacf_scan_t state_r;
    logic [TACF_ROI_BITS-1:0] cur_r;
    logic [TACF_ROI_BITS-1:0] prev_r;
    logic [7:0] idx_r;
    logic [15:0] count_nxt;

    wire logic run = (state_r == TACF_SCAN_RUN);
    wire logic rise = run && cur_r[idx_r] && !prev_r[idx_r];
    wire logic fall = run && !cur_r[idx_r] && prev_r[idx_r];
    wire logic last = run && (idx_r == TACF_SCAN_LAST);

    // rise counts in both modes; a held hotspot never rises again
    always_comb begin
        count_nxt = count_r;
        if (clear) begin
            count_nxt = 16'h0000;
        end else if (rise && count_r != TACF_CNT_MAX) begin
            count_nxt = count_r + 16'h0001;
        end else if (fall && !uni_dir && count_r != 16'h0000) begin
            count_nxt = count_r - 16'h0001;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= TACF_SCAN_IDLE;
            count_r <= 16'h0000;
            idx_r <= 8'h00;
            cur_r <= '0;
            prev_r <= '0;
            busy_r <= 1'b0;
        end else begin
            count_r <= count_nxt;
            case (state_r)
                TACF_SCAN_IDLE: begin
                    // frames arriving mid-scan are dropped, frames are far slower
                    if (frame_pulse) begin
                        cur_r <= hot_bits;
                        idx_r <= 8'h00;
                        busy_r <= 1'b1;
                        state_r <= TACF_SCAN_RUN;
                    end
                end
                default: begin
                    idx_r <= idx_r + 8'h01;
                    if (last) begin
                        prev_r <= cur_r;
                        busy_r <= 1'b0;
                        state_r <= TACF_SCAN_IDLE;
                    end
                end
            endcase
        end
    end
endmodule : tacf_hotspot_counter

// [design/tacf_coil_bank.sv]
// thermal alarm coil flag bank with pixel freeze, hotspot counter and output latch
module tacf_coil_bank #(
    parameter int MS_CYCLES = tacf_pkg::TACF_MS_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // coil access from the serial frame engine
    input wire tacf_pkg::tacf_coil_req_t coil_req,
    output logic coil_ack_r,
    output logic coil_err_r,
    output logic coil_rdata_r,
    // pixel registers
    input wire tacf_pkg::tacf_pix_wr_t pix_wr,
    input wire logic pix_burst_start,
    input wire logic [9:0] pix_burst_addr,
    input wire logic [10:0] pix_burst_len,
    output logic pix_rd_valid_r,
    output logic [15:0] pix_rd_data,
    output logic pix_burst_err_r,
    // application side
    input wire logic frame_pulse,
    input wire logic [255:0] hot_bits,
    input wire logic [2:0] app_alarm_cond,
    output tacf_pkg::tacf_coils_t coils_r,
    output logic [15:0] hotspot_count,
    output logic [2:0] app_alarm_r,
    output logic global_alarm_r,
    // switching output
    input wire logic sw_enable,
    input wire logic sw_timer_mode,
    input wire logic [10:0] sw_on_time_ms,
    output logic sw_active_r,
    // nonvolatile image
    input wire logic nv_restore,
    input wire tacf_pkg::tacf_coils_t nv_image
);
    import tacf_pkg::*;

    tacf_coils_t coils_nxt;
    logic [16:0] pre_r;
    logic [10:0] ms_left_r;
    logic [9:0] burst_addr_r;
    logic [6:0] burst_left_r;
    logic burst_act_r;
    logic [9:0] rd_addr;

    // coil access decode
    wire logic wr = coil_req.wr;
    wire logic wv = coil_req.wdata;
    wire logic [15:0] ca = coil_req.addr;
    wire logic hit_dir = (ca == TACF_ADDR_DIR);
    wire logic hit_en1 = (ca == TACF_ADDR_EN1);
    wire logic hit_en2 = (ca == TACF_ADDR_EN2);
    wire logic hit_en3 = (ca == TACF_ADDR_EN3);
    wire logic hit_frz = (ca == TACF_ADDR_FRZ);
    wire logic hit_lim = (ca == TACF_ADDR_LIM);
    wire logic hit_avg = (ca == TACF_ADDR_AVG);
    wire logic hit_clr = (ca == TACF_ADDR_CLR);
    wire logic hit_crs = (ca == TACF_ADDR_CRS);
    wire logic hit_any = hit_dir | hit_en1 | hit_en2 | hit_en3 | hit_frz | hit_lim
                       | hit_avg | hit_clr | hit_crs;
    wire logic clr_wr0 = wr && hit_clr && !wv;
    wire logic crs_wr1 = wr && hit_crs && wv;

    wire logic rd_bit;
    assign rd_bit = hit_dir ? coils_r.uni_dir :
                    hit_en1 ? coils_r.alarm_en[0] :
                    hit_en2 ? coils_r.alarm_en[1] :
                    hit_en3 ? coils_r.alarm_en[2] :
                    hit_frz ? coils_r.freeze :
                    hit_lim ? coils_r.lim_view :
                    hit_avg ? coils_r.smooth :
                    hit_clr ? coils_r.out_clear :
                    hit_crs ? coils_r.cnt_reset : 1'b0;

    // alarm gating
    wire logic [2:0] alarm_gated = app_alarm_cond & coils_r.alarm_en;
    wire logic alarm_any = |alarm_gated;
    wire logic sw_trigger = alarm_any && sw_enable && !sw_active_r;
    wire logic ms_tick = sw_active_r && (pre_r == 17'(MS_CYCLES - 1));
    wire logic sw_expire = sw_active_r && sw_timer_mode && ms_tick
                         && (ms_left_r <= 11'h001);
    wire logic sw_release = sw_active_r && (clr_wr0 || sw_expire);

    // pixel path; freeze only gates the copy, analysis sees live frames
    wire logic mem_we = pix_wr.valid && !coils_r.freeze;
    wire logic [11:0] burst_end = {2'b00, pix_burst_addr} + {1'b0, pix_burst_len};
    wire logic burst_bad = (pix_burst_len == 11'h000) || (pix_burst_len > TACF_MAX_READ)
                         || (burst_end > TACF_PIX_END);
    wire logic burst_ok = pix_burst_start && !burst_bad && !burst_act_r;
    wire logic mem_re = burst_act_r;
    assign rd_addr = burst_addr_r;

    // coil next state; hardware sets win over master clears
    always_comb begin
        coils_nxt = coils_r;
        if (wr && hit_dir) coils_nxt.uni_dir = wv;
        if (wr && hit_en1) coils_nxt.alarm_en[0] = wv;
        if (wr && hit_en2) coils_nxt.alarm_en[1] = wv;
        if (wr && hit_en3) coils_nxt.alarm_en[2] = wv;
        if (wr && hit_frz) coils_nxt.freeze = wv;
        if (wr && hit_lim) coils_nxt.lim_view = wv;
        if (wr && hit_avg) coils_nxt.smooth = wv;
        if (wr && hit_clr) coils_nxt.out_clear = wv;
        if (sw_expire) coils_nxt.out_clear = 1'b0;
        if (sw_trigger) coils_nxt.out_clear = 1'b1;
        if (coils_r.cnt_reset && hotspot_count == 16'h0000) coils_nxt.cnt_reset = 1'b0;
        if (crs_wr1) coils_nxt.cnt_reset = 1'b1;
        if (nv_restore) begin
            // volatile coils are never taken from the stored image
            coils_nxt = tacf_coils_t'((coils_nxt & ~TACF_RETAIN_MASK)
                      | (nv_image & TACF_RETAIN_MASK));
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            coils_r <= tacf_coils_t'(TACF_COILS_RST);
        end else begin
            coils_r <= coils_nxt;
        end
    end

    // coil access answer, one cycle after the request
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            coil_ack_r <= 1'b0;
            coil_err_r <= 1'b0;
            coil_rdata_r <= 1'b0;
        end else begin
            coil_ack_r <= coil_req.wr | coil_req.rd;
            coil_err_r <= (coil_req.wr | coil_req.rd) && !hit_any;
            coil_rdata_r <= coil_req.rd && rd_bit;
        end
    end

    // alarm flags
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            app_alarm_r <= 3'h0;
            global_alarm_r <= 1'b0;
        end else begin
            app_alarm_r <= alarm_gated;
            global_alarm_r <= alarm_any;
        end
    end

    // switching output latch and on-timer
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sw_active_r <= 1'b0;
            pre_r <= 17'h00000;
            ms_left_r <= 11'h000;
        end else if (sw_trigger) begin
            sw_active_r <= 1'b1;
            pre_r <= 17'h00000;
            ms_left_r <= sw_on_time_ms;
        end else if (sw_release) begin
            sw_active_r <= 1'b0;
            pre_r <= 17'h00000;
        end else if (sw_active_r) begin
            pre_r <= ms_tick ? 17'h00000 : pre_r + 17'h00001;
            if (ms_tick && ms_left_r != 11'h000) begin
                ms_left_r <= ms_left_r - 11'h001;
            end
        end
    end

    // pixel read bursts, one word per cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            burst_act_r <= 1'b0;
            burst_addr_r <= 10'h000;
            burst_left_r <= 7'h00;
            pix_rd_valid_r <= 1'b0;
            pix_burst_err_r <= 1'b0;
        end else begin
            pix_rd_valid_r <= mem_re;
            pix_burst_err_r <= pix_burst_start && (burst_bad || burst_act_r);
            if (burst_ok) begin
                burst_act_r <= 1'b1;
                burst_addr_r <= pix_burst_addr;
                burst_left_r <= pix_burst_len[6:0];
            end else if (burst_act_r) begin
                burst_addr_r <= burst_addr_r + 10'h001;
                burst_left_r <= burst_left_r - 7'h01;
                if (burst_left_r == 7'h01) begin
                    burst_act_r <= 1'b0;
                end
            end
        end
    end

    tacf_pixel_mem u_mem (
        .ref_clk(ref_clk),
        .we(mem_we),
        .waddr(pix_wr.addr),
        .wdata(pix_wr.data),
        .re(mem_re),
        .raddr(rd_addr),
        .rdata_r(pix_rd_data)
    );

    tacf_hotspot_counter u_cnt (
        .ref_clk(ref_clk),
        .rst(rst),
        .frame_pulse(frame_pulse),
        .hot_bits(hot_bits),
        .uni_dir(coils_r.uni_dir),
        .clear(coils_r.cnt_reset),
        .count_r(hotspot_count),
        .busy_r()
    );

    uni_no_dec_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (coils_r.uni_dir && !coils_r.cnt_reset) |=> (hotspot_count >= $past(hotspot_count))
    ) else $error("hotspot counter fell in increment-only mode");

    cnt_clear_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(coils_r.cnt_reset) |=> (hotspot_count == 16'h0000) ##[1:2] !coils_r.cnt_reset
    ) else $error("counter reset did not clear counter and coil");

    crs_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (coils_r.cnt_reset && hotspot_count != 16'h0000 && !nv_restore) |=> coils_r.cnt_reset
    ) else $error("counter reset coil dropped before counter reached zero");

    freeze_gate_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (coils_r.freeze && pix_wr.valid) |-> !mem_we
    ) else $error("pixel store written while frozen");

    alarm_or_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ##1 (global_alarm_r == |($past(app_alarm_cond) & $past(coils_r.alarm_en)))
    ) else $error("global alarm not the OR of enabled alarms");

    sw_gate_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(sw_active_r) |-> ($past(sw_enable) && $past(alarm_any))
    ) else $error("switching output raised without enable and alarm");

    clr_set_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        $rose(sw_active_r) |-> coils_r.out_clear
    ) else $error("output-clear coil not set on output trigger");

    action_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (sw_active_r && !sw_timer_mode && !clr_wr0) |=> sw_active_r
    ) else $error("action-mode output released without master clear");

    burst_len_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (pix_burst_start && pix_burst_len > TACF_MAX_READ) |=> pix_burst_err_r ##1 !pix_rd_valid_r
    ) else $error("over-long pixel read not refused");

    reset_dflt_a: assert property (
        @(posedge ref_clk)
        $fell(rst) |-> (coils_r == tacf_coils_t'(TACF_COILS_RST)) && !sw_active_r
    ) else $error("coils not at default after reset");

    timer_clr_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        sw_expire |=> (!sw_active_r && !coils_r.out_clear)
    ) else $error("timer expiry did not release output and clear coil");

    smooth_wr_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        (wr && hit_avg && !nv_restore) |=> (coils_r.smooth == $past(wv))
    ) else $error("smoothing coil write not stored");

    alarm_mask_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ##1 ((app_alarm_r & ~$past(coils_r.alarm_en)) == 3'h0)
    ) else $error("disabled application raised an alarm");
endmodule : tacf_coil_bank

// [test/tacf_master_model.sv]
// bus master model issuing coil accesses and pixel read bursts
module tacf_master_model (
    // clock
    input wire logic ref_clk,
    // coil access
    output tacf_pkg::tacf_coil_req_t coil_req,
    input wire logic coil_ack_r,
    input wire logic coil_err_r,
    input wire logic coil_rdata_r,
    // pixel read
    output logic pix_burst_start,
    output logic [9:0] pix_burst_addr,
    output logic [10:0] pix_burst_len,
    input wire logic pix_rd_valid_r,
    input wire logic [15:0] pix_rd_data,
    input wire logic pix_burst_err_r
);
    timeunit 1ns;
    timeprecision 100ps;
    import tacf_pkg::*;

    initial begin
        coil_req = '0;
        pix_burst_start = 1'b0;
        pix_burst_addr = 10'h000;
        pix_burst_len = 11'h000;
    end

    // one request pulse; idle lines flip so stale values never pass
    task automatic coil_acc(input logic w, input logic [15:0] a, input logic d,
                            output logic q, output logic [1:0] st);
        @(posedge ref_clk) #1;
        coil_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(posedge ref_clk) #1;
        q = coil_rdata_r;
        st = {coil_ack_r, coil_err_r};
        coil_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : coil_acc

    // master keeps len within 125 unless a refusal is wanted
    task automatic burst(input logic [9:0] a, input logic [10:0] n,
                         output logic [15:0] first, output int cnt, output logic err);
        @(posedge ref_clk) #1;
        pix_burst_start = 1'b1;
        pix_burst_addr = a;
        pix_burst_len = n;
        @(posedge ref_clk) #1;
        pix_burst_start = 1'b0;
        pix_burst_addr = ~a;
        pix_burst_len = ~n;
        cnt = 0;
        err = 1'b0;
        first = 16'h0000;
        repeat (int'(n) + 4) begin
            if (pix_burst_err_r === 1'b1) err = 1'b1;
            if (pix_rd_valid_r === 1'b1) begin
                if (cnt == 0) first = pix_rd_data;
                cnt++;
            end
            @(posedge ref_clk) #1;
        end
    endtask : burst
endmodule : tacf_master_model

// [test/test_thermal_alarm_coil_flags.sv]
// self-checking bench for the thermal alarm coil flag bank
module test_thermal_alarm_coil_flags;
    timeunit 1ns;
    timeprecision 100ps;
    import tacf_pkg::*;

    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    tacf_coil_req_t coil_req;
    logic coil_ack_r, coil_err_r, coil_rdata_r, pix_burst_start;
    logic [9:0] pix_burst_addr;
    logic [10:0] pix_burst_len;
    logic pix_rd_valid_r, pix_burst_err_r, global_alarm_r, sw_active_r;
    logic [15:0] pix_rd_data, hotspot_count;
    tacf_pix_wr_t pix_wr = '0;
    logic frame_pulse = 1'b0;
    logic [255:0] hot_bits = '0;
    logic [2:0] app_alarm_cond = 3'h0;
    logic [2:0] app_alarm_r;
    tacf_coils_t coils_r;
    logic sw_enable = 1'b0;
    logic sw_timer_mode = 1'b0;
    logic [10:0] sw_on_time_ms = 11'h001;
    logic nv_restore = 1'b0;
    tacf_coils_t nv_image = '0;
    int fail_count = 0;
    int cmp_count = 0;
    logic [15:0] first;
    logic [15:0] bad_addr [4] = '{16'h0000, 16'h0003, 16'h000D, 16'hFFFF};
    int cnt;
    logic err;

    initial forever #4 ref_clk = ~ref_clk;

    tacf_coil_bank #(.MS_CYCLES(4)) dut (.ref_clk(ref_clk), .rst(rst), .coil_req(coil_req),
        .coil_ack_r(coil_ack_r), .coil_err_r(coil_err_r), .coil_rdata_r(coil_rdata_r),
        .pix_wr(pix_wr), .pix_burst_start(pix_burst_start), .pix_burst_addr(pix_burst_addr),
        .pix_burst_len(pix_burst_len), .pix_rd_valid_r(pix_rd_valid_r),
        .pix_rd_data(pix_rd_data), .pix_burst_err_r(pix_burst_err_r),
        .frame_pulse(frame_pulse), .hot_bits(hot_bits), .app_alarm_cond(app_alarm_cond),
        .coils_r(coils_r), .hotspot_count(hotspot_count), .app_alarm_r(app_alarm_r),
        .global_alarm_r(global_alarm_r), .sw_enable(sw_enable), .sw_timer_mode(sw_timer_mode),
        .sw_on_time_ms(sw_on_time_ms), .sw_active_r(sw_active_r), .nv_restore(nv_restore),
        .nv_image(nv_image));

    tacf_master_model mm (.ref_clk(ref_clk), .coil_req(coil_req), .coil_ack_r(coil_ack_r),
        .coil_err_r(coil_err_r), .coil_rdata_r(coil_rdata_r), .pix_burst_start(pix_burst_start),
        .pix_burst_addr(pix_burst_addr), .pix_burst_len(pix_burst_len),
        .pix_rd_valid_r(pix_rd_valid_r), .pix_rd_data(pix_rd_data),
        .pix_burst_err_r(pix_burst_err_r));

    task automatic step;
        @(posedge ref_clk) #1;
    endtask : step

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic d);
        logic q;
        logic [1:0] st;
        mm.coil_acc(1'b1, a, d, q, st);
    endtask : wr

    task automatic xc(input logic [15:0] a, input logic d, input logic [1:0] st_exp);
        logic q;
        logic [1:0] st;
        mm.coil_acc(1'b0, a, 1'b0, q, st);
        chk("coil read", {13'h0, st, q}, {13'h0, st_exp, d});
    endtask : xc

    task automatic pw(input logic [9:0] a, input logic [15:0] d);
        step();
        pix_wr = '{valid: 1'b1, addr: a, data: d};
        step();
        pix_wr = '{valid: 1'b0, addr: ~a, data: ~d};
    endtask : pw

    // scan of the hotspot array takes 256 cycles
    task automatic frame(input logic [255:0] b, input logic [15:0] exp);
        step();
        hot_bits = b;
        frame_pulse = 1'b1;
        step();
        frame_pulse = 1'b0;
        hot_bits = ~b;
        repeat (262) step();
        chk("hotspot count", hotspot_count, exp);
    endtask : frame

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : test_done

    // hang guard
    initial begin
        repeat (60000) @(posedge ref_clk);
        fail_count++;
        test_done();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b0;
        for (int a = 4; a <= 12; a++) xc(16'(a), 1'b0, 2'b10);
        foreach (bad_addr[i]) begin
            xc(bad_addr[i], 1'b0, 2'b11);
        end
        for (int a = 4; a < 12; a++) begin
            wr(16'(a), 1'b1);
            chk("coil state", 16'(coils_r), 16'h0001 << (a - 4));
            xc(16'(a), 1'b1, 2'b10);
            wr(16'(a), 1'b0);
        end
        wr(TACF_ADDR_CRS, 1'b0);
        xc(TACF_ADDR_CRS, 1'b0, 2'b10);
        $display("test coil map done");
        // alarm gating and switching output; no trigger while output disabled
        wr(TACF_ADDR_EN1, 1'b1);
        wr(TACF_ADDR_EN3, 1'b1);
        app_alarm_cond = 3'h7;
        repeat (3) step();
        chk("gated alarms", 16'(app_alarm_r), 16'h0005);
        chk("global alarm", 16'(global_alarm_r), 16'h0001);
        chk("switch off", 16'(sw_active_r), 16'h0000);
        app_alarm_cond = 3'h2;
        repeat (2) step();
        chk("global masked", 16'(global_alarm_r), 16'h0000);
        app_alarm_cond = 3'h1;
        sw_enable = 1'b1;
        repeat (2) step();
        chk("switch on", 16'(sw_active_r), 16'h0001);
        app_alarm_cond = 3'h0;
        xc(TACF_ADDR_CLR, 1'b1, 2'b10);
        repeat (20) step();
        chk("action hold", 16'(sw_active_r), 16'h0001);
        wr(TACF_ADDR_CLR, 1'b0);
        step();
        chk("action release", 16'(sw_active_r), 16'h0000);
        sw_timer_mode = 1'b1;
        app_alarm_cond = 3'h1;
        repeat (2) step();
        app_alarm_cond = 3'h0;
        cnt = 0;
        while (sw_active_r === 1'b1 && cnt < 30) begin
            step();
            cnt++;
        end
        chk("timer release", 16'(cnt >= 2 && cnt <= 6), 16'h0001);
        xc(TACF_ADDR_CLR, 1'b0, 2'b10);
        $display("test alarm done");
        // pixel freeze and burst limits
        pw(10'h005, 16'h1234);
        mm.burst(10'h005, 11'h001, first, cnt, err);
        chk("pixel live", first, 16'h1234);
        wr(TACF_ADDR_FRZ, 1'b1);
        pw(10'h005, 16'hABCD);
        mm.burst(10'h005, 11'h001, first, cnt, err);
        chk("pixel frozen", first, 16'h1234);
        // counter keeps running on new frames while frozen
        frame({254'h0, 2'b11}, 16'h0002);
        frame({254'h0, 2'b01}, 16'h0001);
        wr(TACF_ADDR_DIR, 1'b1);
        frame({254'h0, 2'b11}, 16'h0002);
        frame({254'h0, 2'b00}, 16'h0002);
        frame({254'h0, 2'b11}, 16'h0004);
        frame({254'h0, 2'b11}, 16'h0004);
        wr(TACF_ADDR_CRS, 1'b1);
        repeat (3) step();
        chk("counter cleared", hotspot_count, 16'h0000);
        xc(TACF_ADDR_CRS, 1'b0, 2'b10);
        wr(TACF_ADDR_FRZ, 1'b0);
        pw(10'h005, 16'hABCD);
        mm.burst(10'h005, 11'h001, first, cnt, err);
        chk("pixel thawed", first, 16'hABCD);
        mm.burst(10'h383, 11'h07D, first, cnt, err);
        chk("burst 125", {err, 15'(cnt)}, 16'h007D);
        mm.burst(10'h000, 11'h07E, first, cnt, err);
        chk("burst 126", {err, 15'(cnt)}, 16'h8000);
        mm.burst(10'h384, 11'h07D, first, cnt, err);
        chk("burst past end", {err, 15'(cnt)}, 16'h8000);
        $display("test pixel and counter done");
        nv_image = '1;
        step();
        nv_restore = 1'b1;
        step();
        nv_restore = 1'b0;
        step();
        chk("restored coils", 16'(coils_r), 16'h006F);
        $display("test retain done");
        test_done();
    end
endmodule : test_thermal_alarm_coil_flags
